// ---- design/psx_crossconnect.v ----
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`include "psx_map.vh"
module psx_crossconnect
(
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Serial port 0
   input  wire        uart_txd,
   output reg         uart_rxd,
   // Pins
   input  wire        rx_pin,
   output reg         tx_pin,
   output reg         t0ch0_pin_release,
   output reg         t0ch1_pin_release,
   // Timer 0
   input  wire        t0_ch0_out,
   output reg         t0_ch0_in,
   output reg         t0_ch1_in,
   input  wire        t0_ch0_pin_in,
   input  wire        t0_ch1_pin_in,
   input  wire        t0_init_trg,
   // Timer 2
   input  wire        t2_init_trg,
   input  wire        t2_match_trg,
   output reg         t2_cmp_trigger,
   output reg         t2_soft_trigger,
   // Comparators, counter overflow and periodic timers
   input  wire        cmp0_out,
   input  wire        cmp1_out,
   input  wire        rtc_ovf,
   input  wire        pit0_ovf,
   input  wire        pit1_ovf,
   output reg         conv_trigger
);

   reg  [31:0] opt_ff;
   reg  [31:0] nxt_opt;
   reg  [1:0]  rx_sync_ff;
   reg  [1:0]  c0_sync_ff;
   reg  [1:0]  c1_sync_ff;
   reg  [1:0]  p0_sync_ff;
   reg  [1:0]  p1_sync_ff;
   wire        acc;
   wire        wr;
   wire        hit_opt;
   wire        hit_stat;
   wire        tx_mod_en;
   wire        rx_cap_en;
   wire        rx_flt_en;
   wire        t0ic_sel;
   wire        trg_en;
   wire        cmp_sel;
   wire [2:0]  ad_sel;
   wire        cmp_pick;
   reg         ad_src;

   // One decode serves the write path, the read path and the error flag.
   // Keeping it in one place stops the three from drifting apart.
   function addr_hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         addr_hit = (addr == ofs);
      end
   endfunction

   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign hit_opt  = addr_hit(paddr, `PSX_OPT_OFS);
   assign hit_stat = addr_hit(paddr, `PSX_STAT_OFS);

   assign tx_mod_en = opt_ff[`PSX_TXME_BIT];
   assign rx_cap_en = opt_ff[`PSX_RXCE_BIT];
   assign rx_flt_en = opt_ff[`PSX_RXFE_BIT];
   assign t0ic_sel  = opt_ff[`PSX_T0IC_BIT];
   assign trg_en    = opt_ff[`PSX_CTRG_BIT];
   assign cmp_sel   = opt_ff[`PSX_ACSEL_BIT];
   assign ad_sel    = opt_ff[`PSX_ADSEL_MSB:`PSX_ADSEL_LSB];
   assign cmp_pick  = cmp_sel ? c1_sync_ff[1] : c0_sync_ff[1];

   always @*
   begin
      nxt_opt = opt_ff;
      if (wr && hit_opt)
      begin
         // Sync bit is never stored so it always reads zero.
         nxt_opt = pwdata & `PSX_OPT_MASK;
         nxt_opt[`PSX_SYNC_BIT] = 1'b0;
      end
   end

   always @*
   begin
      case (ad_sel)
         `PSX_AD_RTC:     ad_src = rtc_ovf;
         `PSX_AD_T0INIT:  ad_src = t0_init_trg;
         `PSX_AD_T2INIT:  ad_src = t2_init_trg;
         `PSX_AD_T2MATCH: ad_src = t2_match_trg;
         `PSX_AD_PER0:    ad_src = p0_sync_ff[1];
         `PSX_AD_PER1:    ad_src = p1_sync_ff[1];
         `PSX_AD_CMP0:    ad_src = c0_sync_ff[1];
         default:         ad_src = c1_sync_ff[1];
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         opt_ff <= `PSX_OPT_RESET;
      else
         opt_ff <= nxt_opt;
   end

   // Response flags come from flops, so no pin sees a decode glitch.
   // The slave is not ready in reset; after it every access is zero-wait.
   // Unmapped addresses raise an error but never hang the bus.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= 1'b1;
         if (psel && !penable)
            pslverr <= ~hit_opt & ~hit_stat;
         else
            pslverr <= 1'b0;
      end
   end

   // The receive pin, both comparators and both periodic timer overflows pass two flops first.
   // The receive line resets high so the receiver sees an idle line.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_sync_ff <= 2'h3;
         c0_sync_ff <= 2'h0;
         c1_sync_ff <= 2'h0;
         p0_sync_ff <= 2'h0;
         p1_sync_ff <= 2'h0;
      end
      else
      begin
         rx_sync_ff <= {rx_sync_ff[0], rx_pin};
         c0_sync_ff <= {c0_sync_ff[0], cmp0_out};
         c1_sync_ff <= {c1_sync_ff[0], cmp1_out};
         p0_sync_ff <= {p0_sync_ff[0], pit0_ovf};
         p1_sync_ff <= {p1_sync_ff[0], pit1_ovf};
      end
   end

   // Read data is latched in setup and held until the next read.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
      begin
         if (hit_opt)
            prdata <= opt_ff;
         else if (hit_stat)
            prdata <= {29'h0, rx_sync_ff[1], c1_sync_ff[1],
                       c0_sync_ff[1]};
         else
            prdata <= 32'h00000000;
      end
   end

   // Transmit path; the pin resets high, the idle level of the line.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_pin            <= 1'b1;
         t0ch0_pin_release <= 1'b0;
      end
      else
      begin
         if (tx_mod_en)
            tx_pin <= uart_txd & t0_ch0_out;
         else
            tx_pin <= uart_txd;
         t0ch0_pin_release <= tx_mod_en | t0ic_sel;
      end
   end

   // Receive path; it also resets to the idle high level.
   // The comparator output here is already through its synchroniser.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         uart_rxd <= 1'b1;
      else
      begin
         if (rx_flt_en)
            uart_rxd <= cmp_pick;
         else
            uart_rxd <= rx_sync_ff[1];
      end
   end

   // Channel 1 follows whatever the receiver gets, filtered or not.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         t0_ch1_in         <= 1'b0;
         t0ch1_pin_release <= 1'b0;
      end
      else
      begin
         if (rx_cap_en)
         begin
            t0_ch1_in         <= rx_flt_en ? cmp_pick : rx_sync_ff[1];
            t0ch1_pin_release <= 1'b1;
         end
         else
         begin
            t0_ch1_in         <= t0_ch1_pin_in;
            t0ch1_pin_release <= 1'b0;
         end
      end
   end

   // Comparator and counter overflow are ORed, so either one captures.
   // Software that wants only one source must keep the other quiet.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         t0_ch0_in <= 1'b0;
      else
      begin
         if (t0ic_sel)
            t0_ch0_in <= cmp_pick | rtc_ovf;
         else
            t0_ch0_in <= t0_ch0_pin_in;
      end
   end

   // Triggers are registered: one cycle after a direct source, three after a comparator or periodic timer input.
   // A one written to the sync bit gives a single-cycle pulse.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         t2_cmp_trigger  <= 1'b0;
         t2_soft_trigger <= 1'b0;
         conv_trigger    <= 1'b0;
      end
      else
      begin
         t2_cmp_trigger  <= trg_en & cmp_pick;
         t2_soft_trigger <= wr & hit_opt & pwdata[`PSX_SYNC_BIT];
         conv_trigger    <= ad_src;
      end
   end

endmodule

// ---- design/psx_map.vh ----
`ifndef PSX_MAP_VH
`define PSX_MAP_VH
// Register byte offsets.
`define PSX_OPT_OFS        12'h000
`define PSX_STAT_OFS       12'h004
// Option register field positions.
`define PSX_TXME_BIT       0
`define PSX_RXCE_BIT       1
`define PSX_RXFE_BIT       2
`define PSX_T0IC_BIT       3
`define PSX_CTRG_BIT       4
`define PSX_ACSEL_BIT      5
`define PSX_SYNC_BIT       6
`define PSX_ADSEL_LSB      8
`define PSX_ADSEL_MSB      10
`define PSX_OPT_MASK       32'h0000073F
`define PSX_OPT_RESET      32'h00000000
// Converter trigger codes.
`define PSX_AD_RTC         3'h0
`define PSX_AD_T0INIT      3'h1
`define PSX_AD_T2INIT      3'h2
`define PSX_AD_T2MATCH     3'h3
`define PSX_AD_PER0        3'h4
`define PSX_AD_PER1        3'h5
`define PSX_AD_CMP0        3'h6
`define PSX_AD_CMP1        3'h7
`endif

// ---- test/psx_periph_model.sv ----
`timescale 1ns/10ps
module psx_periph_model
(
   // Clock and reset
   input  wire  pclk,
   input  wire  presetn,
   // Serial and timer outputs
   output logic uart_txd,
   output logic t0_ch0_out,
   output logic t0_ch0_pin_in,
   output logic t0_ch1_pin_in
);
   logic [3:0] cnt_ff;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         cnt_ff <= 4'h0;
      else
         cnt_ff <= cnt_ff + 4'h1;
   // both kept running
   // The line idles high in reset, as a real transmitter would.
   assign uart_txd = !presetn | cnt_ff[2];
   assign t0_ch0_out = cnt_ff[0];
   assign t0_ch0_pin_in = cnt_ff[1];
   assign t0_ch1_pin_in = cnt_ff[3];
endmodule

// ---- test/psx_crossconnect_sva.sv ----
`timescale 1ns/10ps
module psx_crossconnect_sva
(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        uart_txd,
   input wire        tx_pin,
   input wire        t0_ch0_out,
   input wire        t0ch0_pin_release,
   input wire        t0ch1_pin_release,
   input wire        t0_ch1_in,
   input wire        t0_ch1_pin_in,
   input wire        t2_soft_trigger,
   input wire        t2_cmp_trigger,
   input wire        conv_trigger,
   input wire        rtc_ovf,
   input wire        t0_init_trg
);
   logic [10:0] m_ff;
   wire         wr = psel & penable & pwrite & (paddr == 12'h000);
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         m_ff <= 11'h0;
      else if (wr)
         m_ff <= pwdata[10:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   tx_gated_a: assert property ($past(m_ff[0]) |->
      tx_pin == $past(uart_txd & t0_ch0_out)) else $error("tx gating");
   tx_pass_a: assert property (!$past(m_ff[0]) |->
      tx_pin == $past(uart_txd)) else $error("tx pass");
   ch0_free_a: assert property ($past(m_ff[0] | m_ff[3]) |->
      t0ch0_pin_release) else $error("ch0 pin held");
   ch1_free_a: assert property (t0ch1_pin_release ==
      $past(m_ff[1])) else $error("ch1 pin release");
   ch1_pin_a: assert property (!$past(m_ff[1]) |->
      t0_ch1_in == $past(t0_ch1_pin_in)) else $error("ch1 source");
   sync_pulse_a: assert property (t2_soft_trigger ==
      $past(wr & pwdata[6])) else $error("sync pulse");
   trig_off_a: assert property (!$past(m_ff[4]) |->
      !t2_cmp_trigger) else $error("timer2 trigger");
   conv_low_a: assert property ($past(m_ff[10:9]) == 2'h0 |->
      conv_trigger == $past(m_ff[8] ? t0_init_trg : rtc_ovf))
      else $error("conv select");
endmodule

// ---- test/psx_crossconnect_bench.sv ----
`timescale 1ns/10ps
module psx_crossconnect_bench;
   logic pclk, presetn, psel, penable, pwrite, rx_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] src;
   logic pready, pslverr, uart_txd, uart_rxd, tx_pin, r0, r1, t0_ch0_out;
   logic t0_ch0_in, t0_ch1_in, p0, p1, t2_cmp_trigger, st, conv_trigger;
   integer n_errors = 0, cmp_count = 0, i;
   logic err_seen;
   psx_periph_model i_per (.pclk(pclk), .presetn(presetn),
      .uart_txd(uart_txd), .t0_ch0_out(t0_ch0_out), .t0_ch0_pin_in(p0),
      .t0_ch1_pin_in(p1));
   psx_crossconnect i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .uart_txd(uart_txd), .uart_rxd(uart_rxd), .rx_pin(rx_pin),
      .tx_pin(tx_pin), .t0ch0_pin_release(r0), .t0ch1_pin_release(r1),
      .t0_ch0_out(t0_ch0_out), .t0_ch0_in(t0_ch0_in),
      .t0_ch1_in(t0_ch1_in), .t0_ch0_pin_in(p0), .t0_ch1_pin_in(p1),
      .t0_init_trg(src[1]), .t2_init_trg(src[2]), .t2_match_trg(src[3]),
      .t2_cmp_trigger(t2_cmp_trigger), .t2_soft_trigger(st),
      .cmp0_out(src[6]), .cmp1_out(src[7]), .rtc_ovf(src[0]),
      .pit0_ovf(src[4]), .pit1_ovf(src[5]), .conv_trigger(conv_trigger));
   always #5 pclk = !pclk;
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task txcheck(input m);
      logic a, b;
      @(posedge pclk);
      #1;
      a = uart_txd;
      b = t0_ch0_out;
      repeat (8)
      begin
         @(posedge pclk);
         #1;
         chk(tx_pin, m ? a & b : a);
         a = uart_txd;
         b = t0_ch0_out;
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d, input [31:0] e);
      integer n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'h1)
         n_errors++;
      err_seen = pslverr;
      if (!w)
         chk(prdata, e);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task route(input [31:0] v, input [7:0] s, input r);
      apb(1'h1, 12'h000, v, 32'h0);
      src <= s;
      rx_pin <= r;
      repeat (5) @(posedge pclk);
      #1;
   endtask
   initial
   begin
      #100000;
      n_errors++;
      summarize();
   end
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      src = 8'h00;
      rx_pin = 1'h1;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 12'h000, 32'h0, 32'h0);
      chk({r0, r1, t2_cmp_trigger, conv_trigger}, 4'h0);
      apb(1'h1, 12'h000, 32'hFFFFFFFF, 32'h0);
      #1;
      chk(st, 1'h1);
      apb(1'h0, 12'h000, 32'h0, 32'h0000073F);
      chk(st, 1'h0);
      chk(err_seen, 1'h0);
      apb(1'h0, 12'h004, 32'h0, 32'h00000004);
      apb(1'h0, 12'h008, 32'h0, 32'h0);
      chk(err_seen, 1'h1);
      $display("register test done");
      route(32'h1, 8'h00, 1'h1);
      txcheck(1'h1);
      chk(r0, 1'h1);
      route(32'h4, 8'h00, 1'h1);
      chk(uart_rxd, 1'h0);
      route(32'h0, 8'h00, 1'h1);
      chk(uart_rxd, 1'h1);
      txcheck(1'h0);
      chk(r0, 1'h0);
      route(32'h2, 8'h00, 1'h1);
      chk(t0_ch1_in, 1'h1);
      route(32'h2, 8'h00, 1'h0);
      chk({t0_ch1_in, r1}, 2'h1);
      route(32'h8, 8'h01, 1'h1);
      chk({t0_ch0_in, r0}, 2'h3);
      route(32'h8, 8'h00, 1'h1);
      chk(t0_ch0_in, 1'h0);
      route(32'h38, 8'h80, 1'h0);
      chk({t0_ch0_in, t2_cmp_trigger}, 2'h3);
      $display("routing test done");
      for (i = 0; i < 8; i++)
      begin
         route(i << 8, 8'h01 << i, 1'h1);
         chk(conv_trigger, 1'h1);
         route(i << 8, ~(8'h01 << i), 1'h1);
         chk(conv_trigger, 1'h0);
      end
      $display("trigger test done");
      summarize();
   end
endmodule
bind psx_crossconnect psx_crossconnect_sva i_sva (.*);
